// *** gcot_consts.svh ***
// register offsets, field positions, reset values and counts for the gate count timer
`ifndef GCOT_CONSTS_SVH
`define GCOT_CONSTS_SVH

`define GCOT_ADDR_W 5
`define GCOT_OFS_MODE 5'h00
`define GCOT_OFS_EDGE 5'h04
`define GCOT_OFS_DATA 5'h08
`define GCOT_OFS_COUNT 5'h0c
`define GCOT_OFS_TRIG 5'h10
`define GCOT_OFS_STATUS 5'h14
`define GCOT_OFS_REWRITE 5'h18
`define GCOT_OFS_OUTPUT 5'h1c

`define GCOT_MODE_CKS_HI 15
`define GCOT_MODE_CKS_LO 14
`define GCOT_MODE_CCS 12
`define GCOT_MODE_MAS 11
`define GCOT_MODE_STS_HI 10
`define GCOT_MODE_STS_LO 8
`define GCOT_MODE_COS_HI 7
`define GCOT_MODE_COS_LO 6
`define GCOT_MODE_MD_HI 4
`define GCOT_MODE_MD_LO 1
`define GCOT_MODE_MD0 0
`define GCOT_EDGE_TIS_HI 1
`define GCOT_EDGE_TIS_LO 0
`define GCOT_TRIG_START 0
`define GCOT_TRIG_STOP 1
`define GCOT_STAT_EN 0
`define GCOT_STAT_RUN 1

`define GCOT_MD_GATE 4'hc
`define GCOT_STS_EXT 3'h2
`define GCOT_TIS_LOW 2'h2
`define GCOT_TIS_HIGH 2'h3

`define GCOT_MODE_RESET 16'h0000
`define GCOT_EDGE_RESET 16'h0000
`define GCOT_DATA_RESET 16'hffff
`define GCOT_COUNT_RESET 16'h0000
`define GCOT_FULL_COUNT 16'hffff
`define GCOT_ZERO_COUNT 16'h0000

`endif

// *** gcot_pkg.sv ***
// types shared by the gate count timer files
package gcot_pkg;

  typedef enum logic [1:0] {
    CH_STOPPED = 2'b00,
    CH_ARMED = 2'b01,
    CH_COUNTING = 2'b10,
    CH_HELD = 2'b11
  } chan_state_t;

  typedef logic [15:0] half_word_t;

endpackage : gcot_pkg

// *** gate_edge_detect.sv ***
// gate pin synchroniser and edge detector
module gate_edge_detect (
  input wire logic mclk,
  input wire logic rst,
  input wire logic gate_input,
  output logic gate_rise,
  output logic gate_fall
);
  logic sync_a;
  logic sync_b;
  logic gate_prev;

  // two flops before any logic looks at the pin
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      gate_prev <= 1'b0;
    end else begin
      sync_a <= gate_input;
      sync_b <= sync_a;
      gate_prev <= sync_b;
    end
  end

  assign gate_rise = sync_b & ~gate_prev;
  assign gate_fall = ~sync_b & gate_prev;

endmodule : gate_edge_detect

// *** gate_count_overflow_timer.sv ***
// gate count overflow timer channel with avalon-mm register slave
// Overview of operation
// - start trigger sets enable, waits for edge
// - first start edge loads ffff, counts down
// - stop edge holds; next start resumes
// - at zero: interrupt, reload ffff, continue
// - select 10: falling starts, rising stops
// - select 11: rising starts, falling stops
// - clock select picks one of four ticks
// - count source 0: operation clock counts
// - trigger source 010: gate edges start/stop
// - mode field 1100 selects gate count
// - start interrupt bit 0: no start interrupt
// - stop trigger halts counter, clears enable
// - after stop, counter frozen and readable
// - stopped channel ignores gate edges
// - channel output pin not driven by counting
// - trigger bits read back as zero
`include "gcot_consts.svh"

module gate_count_overflow_timer (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [`GCOT_ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic prescaled_clock_a,
  input wire logic prescaled_clock_b,
  input wire logic prescaled_clock_c,
  input wire logic prescaled_clock_d,
  input wire logic gate_input,
  output logic channel_interrupt,
  output logic channel_output_pin
);
  import gcot_pkg::*;

  gcot_pkg::half_word_t channel_mode_config;
  gcot_pkg::half_word_t channel_edge_config;
  gcot_pkg::half_word_t channel_data_reg;
  gcot_pkg::half_word_t channel_counter;
  gcot_pkg::chan_state_t state;
  logic [3:0] simul_rewrite;
  logic channel_enable_status;
  logic direct_output;
  logic gate_rise;
  logic gate_fall;
  logic wr_acc;
  logic trig_start;
  logic trig_stop;
  logic tick;
  logic [1:0] input_edge_select;
  logic [1:0] clock_select;
  logic count_clock_source;
  logic [2:0] start_trigger_source;
  logic [3:0] mode_field;
  logic start_interrupt_ctrl;
  logic mode_ok;
  logic start_ev;
  logic stop_ev;

  // merge a byte-enabled write into a 16-bit register
  function automatic half_word_t merge16(input half_word_t old, input logic [31:0] wd,
                                         input logic [3:0] be);
    half_word_t res;
    res = old;
    if (be[0]) begin
      res[7:0] = wd[7:0];
    end
    if (be[1]) begin
      res[15:8] = wd[15:8];
    end
    return res;
  endfunction : merge16

  function automatic logic hit(input logic [`GCOT_ADDR_W-1:0] a,
                               input logic [`GCOT_ADDR_W-1:0] ofs);
    return a == ofs;
  endfunction : hit

  gate_edge_detect u_edge (
    .mclk(mclk),
    .rst(rst),
    .gate_input(gate_input),
    .gate_rise(gate_rise),
    .gate_fall(gate_fall)
  );

  assign input_edge_select = channel_edge_config[`GCOT_EDGE_TIS_HI:`GCOT_EDGE_TIS_LO];
  assign clock_select = channel_mode_config[`GCOT_MODE_CKS_HI:`GCOT_MODE_CKS_LO];
  assign count_clock_source = channel_mode_config[`GCOT_MODE_CCS];
  assign start_trigger_source = channel_mode_config[`GCOT_MODE_STS_HI:`GCOT_MODE_STS_LO];
  assign mode_field = channel_mode_config[`GCOT_MODE_MD_HI:`GCOT_MODE_MD_LO];
  assign start_interrupt_ctrl = channel_mode_config[`GCOT_MODE_MD0];

  // bus handshake: a request is answered on the second edge it is seen
  assign wr_acc = write & ~waitrequest;
  assign trig_start = wr_acc & hit(address, `GCOT_OFS_TRIG) & byteenable[0]
                      & writedata[`GCOT_TRIG_START];
  assign trig_stop = wr_acc & hit(address, `GCOT_OFS_TRIG) & byteenable[0]
                     & writedata[`GCOT_TRIG_STOP];

  // operation clock choice; other count sources are not part of this function
  always_comb begin
    case (clock_select)
      2'b00: tick = prescaled_clock_a;
      2'b01: tick = prescaled_clock_b;
      2'b10: tick = prescaled_clock_c;
      2'b11: tick = prescaled_clock_d;
      default: tick = 1'b0;
    endcase
  end

  // gate count only runs with the gate mode, external trigger source, source bit clear and edge select 10 or 11
  assign mode_ok = (mode_field == `GCOT_MD_GATE)
                   & (start_trigger_source == `GCOT_STS_EXT)
                   & ~count_clock_source
                   & input_edge_select[1];

  always_comb begin
    start_ev = 1'b0;
    stop_ev = 1'b0;
    if (mode_ok) begin
      if (input_edge_select == `GCOT_TIS_HIGH) begin
        start_ev = gate_rise;
        stop_ev = gate_fall;
      end else begin
        start_ev = gate_fall;
        stop_ev = gate_rise;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      waitrequest <= 1'b1;
    end else begin
      waitrequest <= ~((read | write) & waitrequest);
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      readdata <= 32'h0000_0000;
    end else if (read & waitrequest) begin
      case (address)
        `GCOT_OFS_MODE: readdata <= {16'h0000, channel_mode_config};
        `GCOT_OFS_EDGE: readdata <= {16'h0000, channel_edge_config};
        `GCOT_OFS_DATA: readdata <= {16'h0000, channel_data_reg};
        `GCOT_OFS_COUNT: readdata <= {16'h0000, channel_counter};
        `GCOT_OFS_TRIG: readdata <= 32'h0000_0000;
        `GCOT_OFS_STATUS: readdata <= {30'h0000_0000, state == CH_COUNTING,
                                       channel_enable_status};
        `GCOT_OFS_REWRITE: readdata <= {28'h000_0000, simul_rewrite};
        `GCOT_OFS_OUTPUT: readdata <= {31'h0000_0000, direct_output};
        default: readdata <= 32'h0000_0000;
      endcase
    end
  end

  // configuration registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      channel_mode_config <= `GCOT_MODE_RESET;
      channel_edge_config <= `GCOT_EDGE_RESET;
      channel_data_reg <= `GCOT_DATA_RESET;
      simul_rewrite <= 4'h0;
    end else if (wr_acc) begin
      case (address)
        `GCOT_OFS_MODE: channel_mode_config <= merge16(channel_mode_config, writedata, byteenable);
        `GCOT_OFS_EDGE: channel_edge_config <= merge16(channel_edge_config, writedata, byteenable);
        `GCOT_OFS_DATA: channel_data_reg <= merge16(channel_data_reg, writedata, byteenable);
        `GCOT_OFS_REWRITE: begin
          if (byteenable[0]) begin
            simul_rewrite <= writedata[3:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // the pin follows software only: direct output, never the counter
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      direct_output <= 1'b0;
      channel_output_pin <= 1'b0;
    end else begin
      if (wr_acc & hit(address, `GCOT_OFS_OUTPUT) & byteenable[0]) begin
        direct_output <= writedata[0];
      end
      channel_output_pin <= direct_output;
    end
  end

  // enable status; stop wins when both triggers arrive together
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      channel_enable_status <= 1'b0;
    end else if (trig_stop) begin
      channel_enable_status <= 1'b0;
    end else if (trig_start) begin
      channel_enable_status <= 1'b1;
    end
  end

  // channel state; a start while already enabled is ignored since a restart is unsupported
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= CH_STOPPED;
    end else if (trig_stop) begin
      state <= CH_STOPPED;
    end else begin
      case (state)
        CH_STOPPED: begin
          if (trig_start) begin
            state <= CH_ARMED;
          end
        end
        CH_ARMED: begin
          if (start_ev) begin
            state <= CH_COUNTING;
          end
        end
        CH_COUNTING: begin
          if (stop_ev) begin
            state <= CH_HELD;
          end
        end
        CH_HELD: begin
          if (start_ev) begin
            state <= CH_COUNTING;
          end
        end
        default: state <= CH_STOPPED;
      endcase
    end
  end

  // counter; in stopped or held states it keeps its value
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      channel_counter <= `GCOT_COUNT_RESET;
    end else if (!trig_stop) begin
      if (state == CH_ARMED && start_ev) begin
        channel_counter <= `GCOT_FULL_COUNT;
      end else if (state == CH_COUNTING && tick) begin
        if (channel_counter == `GCOT_ZERO_COUNT) begin
          channel_counter <= `GCOT_FULL_COUNT;
        end else begin
          channel_counter <= channel_counter - 16'h0001;
        end
      end
    end
  end

  // one mclk pulse per underflow, taken on the qualifying tick
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      channel_interrupt <= 1'b0;
    end else begin
      channel_interrupt <= (~trig_stop & state == CH_COUNTING & tick
                            & channel_counter == `GCOT_ZERO_COUNT)
                           | (~trig_stop & state == CH_ARMED & start_ev
                              & start_interrupt_ctrl);
    end
  end

  a_bus_answer: assert property (@(posedge mclk) disable iff (rst)
    (read | write) & waitrequest |=> ~waitrequest)
    else $error("bus request not answered in one cycle");

  a_trig_zero: assert property (@(posedge mclk) disable iff (rst)
    read & ~waitrequest & address == `GCOT_OFS_TRIG |-> readdata == 32'h0000_0000)
    else $error("trigger register did not read zero");

  a_start_enable: assert property (@(posedge mclk) disable iff (rst)
    trig_start & ~trig_stop & state == CH_STOPPED
    |=> channel_enable_status & state == CH_ARMED & $stable(channel_counter))
    else $error("start trigger did not enable and wait");

  a_first_load: assert property (@(posedge mclk) disable iff (rst)
    state == CH_ARMED & start_ev & ~trig_stop
    |=> channel_counter == 16'hffff & state == CH_COUNTING)
    else $error("first start edge did not load full count");

  a_count_down: assert property (@(posedge mclk) disable iff (rst)
    state == CH_COUNTING & tick & ~trig_stop & channel_counter != 16'h0000
    |=> channel_counter == $past(channel_counter) - 16'h0001)
    else $error("counter did not decrement on tick");

  a_underflow_irq: assert property (@(posedge mclk) disable iff (rst)
    state == CH_COUNTING & tick & ~trig_stop & channel_counter == 16'h0000
    |=> channel_interrupt & channel_counter == 16'hffff ##1 ~channel_interrupt)
    else $error("underflow did not interrupt and reload");

  a_held_value: assert property (@(posedge mclk) disable iff (rst)
    state == CH_HELD & ~start_ev |=> $stable(channel_counter) & ~channel_interrupt)
    else $error("held counter changed");

  a_stop_clears: assert property (@(posedge mclk) disable iff (rst)
    trig_stop |=> ~channel_enable_status & state == CH_STOPPED ##1 $stable(channel_counter))
    else $error("stop trigger did not halt channel");

  a_stopped_ignore: assert property (@(posedge mclk) disable iff (rst)
    state == CH_STOPPED & ~trig_start |=> $stable(channel_counter) & ~channel_interrupt)
    else $error("stopped channel reacted to gate");

  a_pin_static: assert property (@(posedge mclk) disable iff (rst)
    $changed(channel_output_pin) |-> $past(direct_output) != $past(channel_output_pin))
    else $error("output pin moved without direct output write");

  c_underflow: cover property (@(posedge mclk) disable iff (rst)
    channel_interrupt);
  c_resume: cover property (@(posedge mclk) disable iff (rst)
    state == CH_HELD ##1 state == CH_COUNTING);
  c_sw_stop: cover property (@(posedge mclk) disable iff (rst)
    state == CH_COUNTING ##1 state == CH_STOPPED);

endmodule : gate_count_overflow_timer

// *** gate_far_side.sv ***
// far-side model: tick sources and the gate pin driver
module gate_far_side (
  input wire logic mclk,
  input wire logic rst,
  input wire logic gate_level,
  output logic gate_input,
  output logic [3:0] tick
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] div;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) div <= 3'h0;
    else div <= div + 3'h1;
  end
  // divide by 1, 2, 4 and 8 so each select gives a distinct count rate
  assign tick = {div == 3'h7, div[1:0] == 2'h3, div[0], 1'b1};
  // push-pull pin: the model re-times the bench command, never floats it
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) gate_input <= 1'b0;
    else gate_input <= gate_level;
  end
endmodule : gate_far_side

// *** tb_top.sv ***
// self-checking bench for the gate count overflow timer
`include "gcot_consts.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0, rst = 1'b1, read = 1'b0, write = 1'b0, gate_level = 1'b0;
  logic [4:0] address = 5'h00;
  logic [31:0] writedata = 32'h0, readdata;
  logic [3:0] byteenable = 4'h0, tick;
  logic waitrequest, gate_input, channel_interrupt, channel_output_pin;
  int n_errors = 0, tests_run = 0, n_irq = 0;
  logic [31:0] c1, c2, c3;
  always #20 mclk = ~mclk;
  always @(posedge mclk) if (channel_interrupt === 1'b1) n_irq++;
  gate_far_side far (.mclk(mclk), .rst(rst), .gate_level(gate_level),
    .gate_input(gate_input), .tick(tick));
  gate_count_overflow_timer dut (.mclk(mclk), .rst(rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .prescaled_clock_a(tick[0]), .prescaled_clock_b(tick[1]),
    .prescaled_clock_c(tick[2]), .prescaled_clock_d(tick[3]), .gate_input(gate_input),
    .channel_interrupt(channel_interrupt), .channel_output_pin(channel_output_pin));

  task automatic end_of_test;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  task automatic fail(input string m);
    n_errors++;
    $display("MISMATCH %0t %s", $time, m);
  endtask : fail
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp) fail(m);
  endtask : chk
  task automatic rng(input logic [31:0] got, input int unsigned lo, input int unsigned hi,
    input string m);
    tests_run++;
    if ((got >= lo && got <= hi) !== 1'b1) fail(m);
  endtask : rng
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc
  // one avalon transfer, held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [4:0] a, input logic [15:0] d,
    output logic [31:0] q);
    int n;
    @(posedge mclk);
    address <= a;
    write <= wr;
    read <= !wr;
    writedata <= {16'h0000, d};
    byteenable <= 4'h3;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (n >= 50) begin
      fail("bus timeout");
      end_of_test();
    end
  endtask : bus
  task automatic rd(input logic [4:0] a, output logic [31:0] q);
    bus(1'b0, a, 16'h0000, q);
  endtask : rd
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  function automatic logic [15:0] mode_word(input logic [1:0] k);
    return {k, 3'b000, `GCOT_STS_EXT, 3'b000, `GCOT_MD_GATE, 1'b0};
  endfunction : mode_word

  task automatic sc_reset;
    chk(waitrequest, 1'b1, "idle waitrequest");
    rd(`GCOT_OFS_MODE, c1); chk(c1, 32'h0, "mode reset");
    rd(`GCOT_OFS_EDGE, c1); chk(c1, 32'h0, "edge reset");
    rd(`GCOT_OFS_DATA, c1); chk(c1, 32'hffff, "data reset");
    rd(`GCOT_OFS_COUNT, c1); chk(c1, 32'h0, "count reset");
    rd(`GCOT_OFS_STATUS, c1); chk(c1, 32'h0, "status reset");
    rd(5'h1e, c1); chk(c1, 32'h0, "unmapped read");
  endtask : sc_reset
  task automatic sc_start;
    wr(`GCOT_OFS_DATA, 16'hffff);
    wr(`GCOT_OFS_REWRITE, 16'h0000);
    wr(`GCOT_OFS_MODE, mode_word(2'b00));
    wr(`GCOT_OFS_EDGE, `GCOT_TIS_HIGH);
    wr(`GCOT_OFS_TRIG, 16'h0001);
    rd(`GCOT_OFS_TRIG, c1); chk(c1, 32'h0, "trigger readback");
    rd(`GCOT_OFS_STATUS, c1); chk(c1[0], 1'b1, "enable after start");
    cyc(20);
    rd(`GCOT_OFS_COUNT, c1); chk(c1, 32'h0, "counting before edge");
    chk(n_irq, 0, "start interrupt");
  endtask : sc_start
  task automatic sc_gate;
    gate_level <= 1'b1;
    cyc(6);
    rd(`GCOT_OFS_COUNT, c1); rng(c1, 32'hfff3, 32'hffff, "load at start edge");
    cyc(10);
    rd(`GCOT_OFS_COUNT, c2); rng(c1 - c2, 10, 16, "count down rate");
    gate_level <= 1'b0;
    cyc(6);
    rd(`GCOT_OFS_COUNT, c1);
    cyc(10);
    rd(`GCOT_OFS_COUNT, c2); chk(c2, c1, "hold at stop edge");
    rd(`GCOT_OFS_STATUS, c3); chk(c3, 32'h1, "status while held");
    gate_level <= 1'b1;
    cyc(8);
    rd(`GCOT_OFS_COUNT, c3); rng(c1 - c3, 1, 14, "resume without reload");
    rd(`GCOT_OFS_STATUS, c2); chk(c2, 32'h3, "status while counting");
  endtask : sc_gate
  task automatic sc_underflow;
    int n;
    rd(`GCOT_OFS_COUNT, c1);
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (channel_interrupt !== 1'b1 && n < 70000);
    if (n >= 70000) begin
      fail("no underflow interrupt");
      end_of_test();
    end
    rng(n, c1 - 10, c1 + 10, "underflow moment");
    @(posedge mclk);
    chk(channel_interrupt, 1'b0, "interrupt width");
    rd(`GCOT_OFS_COUNT, c1); rng(c1, 32'hfff5, 32'hffff, "reload after zero");
    chk(n_irq, 1, "one pulse per underflow");
    chk(channel_output_pin, 1'b0, "output pin while counting");
  endtask : sc_underflow
  task automatic sc_stop;
    wr(`GCOT_OFS_TRIG, 16'h0002);
    rd(`GCOT_OFS_STATUS, c1); chk(c1[0], 1'b0, "enable after stop");
    rd(`GCOT_OFS_COUNT, c1);
    for (int i = 0; i < 3; i++) begin
      gate_level <= i[0];
      cyc(6);
    end
    rd(`GCOT_OFS_COUNT, c2); chk(c2, c1, "frozen after stop");
    chk(n_irq, 1, "interrupt while stopped");
  endtask : sc_stop
  // each select, alternating idle level low and high so both edge senses are driven
  task automatic sc_clocks;
    int dv;
    logic idle;
    for (int k = 0; k < 4; k++) begin
      dv = 1 << k;
      idle = k[0];
      wr(`GCOT_OFS_TRIG, 16'h0002);
      gate_level <= idle;
      cyc(6);
      wr(`GCOT_OFS_MODE, mode_word(k[1:0]) | 16'(k == 3));
      wr(`GCOT_OFS_EDGE, idle ? `GCOT_TIS_LOW : `GCOT_TIS_HIGH);
      wr(`GCOT_OFS_TRIG, 16'h0001);
      gate_level <= !idle;
      cyc(6);
      rd(`GCOT_OFS_COUNT, c1); rng(c1, 32'hfff3, 32'hffff, "load per select");
      cyc(64);
      rd(`GCOT_OFS_COUNT, c2);
      rng(c1 - c2, 64 / dv - 1, 72 / dv + 2, "select rate");
      gate_level <= idle;
      cyc(6);
      rd(`GCOT_OFS_COUNT, c1);
      cyc(20);
      rd(`GCOT_OFS_COUNT, c2); chk(c2, c1, "stop edge per sense");
    end
    chk(n_irq, 2, "start interrupt only with md0 set");
  endtask : sc_clocks
  // count source bit set: the channel arms but gate edges must not start counting
  task automatic sc_bad_mode;
    wr(`GCOT_OFS_TRIG, 16'h0002);
    gate_level <= 1'b0;
    cyc(6);
    wr(`GCOT_OFS_EDGE, `GCOT_TIS_HIGH);
    wr(`GCOT_OFS_MODE, mode_word(2'b00) | 16'h1000);
    wr(`GCOT_OFS_TRIG, 16'h0001);
    rd(`GCOT_OFS_COUNT, c1);
    gate_level <= 1'b1;
    cyc(12);
    rd(`GCOT_OFS_COUNT, c2); chk(c2, c1, "count source set must not count");
    rd(`GCOT_OFS_STATUS, c3); chk(c3, 32'h1, "armed but not counting");
  endtask : sc_bad_mode
  task automatic sc_output;
    wr(`GCOT_OFS_OUTPUT, 16'h0001);
    cyc(2);
    chk(channel_output_pin, 1'b1, "direct output high");
    wr(`GCOT_OFS_OUTPUT, 16'h0000);
    cyc(2);
    chk(channel_output_pin, 1'b0, "direct output low");
  endtask : sc_output

  initial begin
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    sc_reset();
    sc_start();
    sc_gate();
    sc_underflow();
    sc_stop();
    sc_clocks();
    sc_bad_mode();
    sc_output();
    end_of_test();
  end
endmodule : tb_top
